// file: rtl/smcc_channel_control.sv
// Stream-to-memory channel control register and run/stop/reset sequencer
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Contract
// - Run/stop written 0: stop taking work, halt after in-flight work ends.
// - Chained mode stop: descriptor write-backs drain before halting.
// - Direct mode stop: pending transfers flushed, streams may end early.
// - Halted indication reads 1 once the engine has really halted.
// - Hardware clears run/stop on error; software may clear it too.
// - Writing run/stop 1 starts; halted returns to 0 when running.
// - Control bit 1 ignores writes and reads 1.
// - Soft reset bit starts graceful reset, flushing, ending streams with last.
// - Soft reset from either channel resets the whole engine.
// - After soft reset every register holds its reset value.
// - Soft reset bit reads 1 during reset, 0 otherwise.
// - Fixed-address bit makes memory writes fixed, non-incrementing bursts.
// - Fixed-address bursts are at most 16 beats.
// - Fixed-address bit has no effect in multichannel configuration.
// - Cyclic bit makes descriptor fetch ignore the completed flag.
// - Cyclic bit has no effect in multichannel or direct register mode.
// - Control bits 11 to 5 ignore writes and read zero.
// - Completion interrupt enable gates completion events onto the interrupt.
// ------------------------------------------------------------
module smcc_channel_control (
    // Clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // Configuration straps
    input  wire logic                          sg_mode,
    input  wire logic                          multichannel,
    // AXI4-Lite write address and data
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [smcc_pkg::ADDR_W-1:0]   awaddr,
    input  wire logic [2:0]                    awprot,
    input  wire logic                          wvalid,
    output logic                               wready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    // AXI4-Lite write response
    output logic                               bvalid,
    input  wire logic                          bready,
    output logic [1:0]                         bresp,
    // AXI4-Lite read
    input  wire logic                          arvalid,
    output logic                               arready,
    input  wire logic [smcc_pkg::ADDR_W-1:0]   araddr,
    input  wire logic [2:0]                    arprot,
    output logic                               rvalid,
    input  wire logic                          rready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    // Engine side
    input  wire smcc_pkg::smcc_eng_stat_t      eng_stat,
    output smcc_pkg::smcc_eng_ctrl_t           eng_ctrl
);

    smcc_pkg::smcc_all_t s;
    smcc_pkg::smcc_all_t next_s;
    smcc_pkg::smcc_all_t reset_s;

    logic        quiet_stop;
    logic        quiet_reset;
    logic        do_write;
    logic        reset_req;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;

    // ------------------------------------------------------------
    // Reset image
    // ------------------------------------------------------------
    always_comb begin
        reset_s                 = '0;
        reset_s.state           = smcc_pkg::ST_HALTED;
        reset_s.regs            = smcc_pkg::REGS_RESET;
        reset_s.ctrl.halted     = 1'b1;
        reset_s.ctrl.aw_burst   = smcc_pkg::BURST_INCR;
        reset_s.ctrl.aw_len_max = smcc_pkg::LEN_MAX_INCR;
        reset_s.bus.awready     = 1'b1;
        reset_s.bus.wready      = 1'b1;
        reset_s.bus.arready     = 1'b1;
    end

    // ------------------------------------------------------------
    // Read words
    // ------------------------------------------------------------
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[smcc_pkg::RUN_STOP_BIT]   = s.regs.run_stop;
        ctrl_word[smcc_pkg::FIXED_ONE_BIT]  = 1'b1;
        ctrl_word[smcc_pkg::SOFT_RESET_BIT] = s.regs.soft_reset;
        ctrl_word[smcc_pkg::FIXED_ADDR_BIT] = s.regs.fixed_addr;
        ctrl_word[smcc_pkg::CYCLIC_BIT]     = s.regs.cyclic;
        ctrl_word[smcc_pkg::COMPLETION_BIT] = s.regs.completion_irq_enable;
        stat_word = 32'h0000_0000;
        stat_word[smcc_pkg::STAT_HALTED_BIT]    = s.ctrl.halted;
        stat_word[smcc_pkg::STAT_STOPPING_BIT]  = (s.state == smcc_pkg::ST_STOPPING);
        stat_word[smcc_pkg::STAT_RESETTING_BIT] = (s.state == smcc_pkg::ST_RESETTING);
        stat_word[smcc_pkg::STAT_BUSY_BIT]      = eng_stat.busy;
    end

    // On stop, chained mode also waits for descriptor write-backs, direct mode does not; reset waits for them in both
    assign quiet_stop  = !eng_stat.busy && !(sg_mode && eng_stat.update_pending);
    assign quiet_reset = !eng_stat.busy && !eng_stat.update_pending;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s   = s;
        do_write = 1'b0;
        reset_req = 1'b0;

        // Write channels are taken independently, in either order
        if (awvalid && s.bus.awready) begin
            next_s.bus.aw_full = 1'b1;
            next_s.bus.aw_addr = awaddr;
        end
        if (wvalid && s.bus.wready) begin
            next_s.bus.w_full = 1'b1;
            next_s.bus.wdata  = wdata;
            next_s.bus.wstrb  = wstrb;
        end
        if (bready && s.bus.bvalid) begin
            next_s.bus.bvalid = 1'b0;
        end
        if (next_s.bus.aw_full && next_s.bus.w_full && !next_s.bus.bvalid) begin
            do_write           = 1'b1;
            next_s.bus.aw_full = 1'b0;
            next_s.bus.w_full  = 1'b0;
            next_s.bus.bvalid  = 1'b1;
            next_s.bus.bresp   = smcc_pkg::RESP_SLVERR;
            if (next_s.bus.aw_addr == smcc_pkg::WRITE_CHANNEL_CONTROL_OFFSET) begin
                next_s.bus.bresp = smcc_pkg::RESP_OKAY;
                // Bits 1 and 11..5 have no storage, so writes to them vanish
                if (next_s.bus.wstrb[0]) begin
                    next_s.regs.run_stop   = next_s.bus.wdata[smcc_pkg::RUN_STOP_BIT];
                    next_s.regs.fixed_addr = next_s.bus.wdata[smcc_pkg::FIXED_ADDR_BIT];
                    next_s.regs.cyclic     = next_s.bus.wdata[smcc_pkg::CYCLIC_BIT];
                    // Writing 0 never cancels a reset already under way
                    if (next_s.bus.wdata[smcc_pkg::SOFT_RESET_BIT]) begin
                        next_s.regs.soft_reset = 1'b1;
                        reset_req              = 1'b1;
                    end
                end
                if (next_s.bus.wstrb[1]) begin
                    next_s.regs.completion_irq_enable =
                        next_s.bus.wdata[smcc_pkg::COMPLETION_BIT];
                end
            end else if (next_s.bus.aw_addr == smcc_pkg::WRITE_CHANNEL_STATUS_OFFSET) begin
                next_s.bus.bresp = smcc_pkg::RESP_OKAY;
            end
        end
        next_s.bus.awready = !next_s.bus.aw_full;
        next_s.bus.wready  = !next_s.bus.w_full;

        // Read channel: one outstanding read, answered the cycle after it is taken
        if (rready && s.bus.rvalid) begin
            next_s.bus.rvalid = 1'b0;
        end
        if (arvalid && s.bus.arready) begin
            next_s.bus.rvalid  = 1'b1;
            next_s.bus.rd_ctrl = 1'b0;
            next_s.bus.rdata   = 32'h0000_0000;
            next_s.bus.rresp   = smcc_pkg::RESP_SLVERR;
            if (araddr == smcc_pkg::WRITE_CHANNEL_CONTROL_OFFSET) begin
                next_s.bus.rd_ctrl = 1'b1;
                next_s.bus.rdata   = ctrl_word;
                next_s.bus.rresp   = smcc_pkg::RESP_OKAY;
            end else if (araddr == smcc_pkg::WRITE_CHANNEL_STATUS_OFFSET) begin
                next_s.bus.rdata = stat_word;
                next_s.bus.rresp = smcc_pkg::RESP_OKAY;
            end
        end
        next_s.bus.arready = !next_s.bus.rvalid;

        // Hardware events override software
        if (eng_stat.error_event) begin
            next_s.regs.run_stop = 1'b0;
        end
        if (eng_stat.peer_reset_req) begin
            next_s.regs.soft_reset = 1'b1;
            reset_req              = 1'b1;
        end

        // ------------------------------------------------------------
        // Run/stop/reset sequencer
        // ------------------------------------------------------------
        case (s.state)
            smcc_pkg::ST_HALTED: begin
                if (next_s.regs.soft_reset) begin
                    next_s.state = smcc_pkg::ST_RESETTING;
                end else if (next_s.regs.run_stop) begin
                    next_s.state = smcc_pkg::ST_RUNNING;
                end
            end
            smcc_pkg::ST_RUNNING: begin
                if (next_s.regs.soft_reset) begin
                    next_s.state = smcc_pkg::ST_RESETTING;
                end else if (!next_s.regs.run_stop) begin
                    next_s.state = smcc_pkg::ST_STOPPING;
                end
            end
            smcc_pkg::ST_STOPPING: begin
                // A restart during the drain waits until the halt is reached
                if (next_s.regs.soft_reset) begin
                    next_s.state = smcc_pkg::ST_RESETTING;
                end else if (quiet_stop) begin
                    next_s.state = smcc_pkg::ST_HALTED;
                end
            end
            smcc_pkg::ST_RESETTING: begin
                // A request landing in the last cycle keeps the reset going, not lost
                if (quiet_reset && !reset_req) begin
                    // Bus handshake state survives so a pending answer is not lost
                    next_s.state = smcc_pkg::ST_HALTED;
                    next_s.regs  = smcc_pkg::REGS_RESET;
                end
            end
            default: begin
                next_s.state = smcc_pkg::ST_HALTED;
                next_s.regs  = smcc_pkg::REGS_RESET;
            end
        endcase

        // ------------------------------------------------------------
        // Engine controls, registered with the state they belong to
        // ------------------------------------------------------------
        next_s.ctrl.accept_work   = (next_s.state == smcc_pkg::ST_RUNNING);
        next_s.ctrl.halted        = (next_s.state == smcc_pkg::ST_HALTED);
        next_s.ctrl.flush_pending = (next_s.state == smcc_pkg::ST_RESETTING)
                                  || ((next_s.state == smcc_pkg::ST_STOPPING) && !sg_mode);
        next_s.ctrl.terminate_streams = (next_s.state == smcc_pkg::ST_RESETTING)
                                      || (next_s.state == smcc_pkg::ST_STOPPING);
        next_s.ctrl.engine_reset  = (next_s.state == smcc_pkg::ST_RESETTING);
        if (next_s.regs.fixed_addr && !multichannel) begin
            next_s.ctrl.aw_burst   = smcc_pkg::BURST_FIXED;
            next_s.ctrl.aw_len_max = smcc_pkg::LEN_MAX_FIXED;
        end else begin
            next_s.ctrl.aw_burst   = smcc_pkg::BURST_INCR;
            next_s.ctrl.aw_len_max = smcc_pkg::LEN_MAX_INCR;
        end
        next_s.ctrl.ignore_complete = next_s.regs.cyclic && sg_mode
                                    && !multichannel;
        next_s.ctrl.completion_irq  = eng_stat.completion_event && eng_stat.complete_flag
                                    && s.regs.completion_irq_enable;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= reset_s;
        end else begin
            s <= next_s;
        end
    end

    assign awready  = s.bus.awready;
    assign wready   = s.bus.wready;
    assign bvalid   = s.bus.bvalid;
    assign bresp    = s.bus.bresp;
    assign arready  = s.bus.arready;
    assign rvalid   = s.bus.rvalid;
    assign rdata    = s.bus.rdata;
    assign rresp    = s.bus.rresp;
    assign eng_ctrl = s.ctrl;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_stop_halts_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.state == smcc_pkg::ST_STOPPING) && !next_s.regs.soft_reset && quiet_stop
        |=> s.ctrl.halted && !s.ctrl.accept_work)
        else $error("stop did not halt once idle");

    chk_no_work_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
        s.ctrl.accept_work |-> s.regs.run_stop && !s.regs.soft_reset)
        else $error("work accepted while stopped");

    chk_updates_drain: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.state == smcc_pkg::ST_STOPPING) && sg_mode && eng_stat.update_pending
        |=> !s.ctrl.halted)
        else $error("halted with descriptor updates pending");

    chk_direct_flush: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.state == smcc_pkg::ST_STOPPING) && !sg_mode |-> s.ctrl.flush_pending)
        else $error("direct mode stop without flush");

    chk_error_clears_run: assert property (@(posedge aclk) disable iff (!aresetn)
        eng_stat.error_event |=> !s.regs.run_stop && !s.ctrl.accept_work)
        else $error("error did not stop the channel");

    chk_run_clears_halt: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s.regs.run_stop) && !s.regs.soft_reset && $past(s.ctrl.halted)
        |-> !s.ctrl.halted && s.ctrl.accept_work)
        else $error("run did not leave halted state");

    chk_reserved_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        s.bus.rvalid && s.bus.rd_ctrl
        |-> s.bus.rdata[smcc_pkg::FIXED_ONE_BIT]
            && (s.bus.rdata[smcc_pkg::RSVD_HI_BIT:smcc_pkg::RSVD_LO_BIT] == 7'h00))
        else $error("reserved control bits read wrong");

    chk_peer_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        eng_stat.peer_reset_req |=> s.regs.soft_reset && s.ctrl.engine_reset)
        else $error("peer reset request ignored");

    chk_reset_restores: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(s.regs.soft_reset)
        |-> (s.regs == smcc_pkg::REGS_RESET) && s.ctrl.halted && !s.ctrl.engine_reset)
        else $error("soft reset left registers set");

    chk_fixed_burst: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.ctrl.aw_burst == smcc_pkg::BURST_FIXED)
        |-> (s.ctrl.aw_len_max == smcc_pkg::LEN_MAX_FIXED) && s.regs.fixed_addr
            && !multichannel)
        else $error("fixed burst mode inconsistent");

    chk_cyclic_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        s.ctrl.ignore_complete |-> s.regs.cyclic && sg_mode && !multichannel)
        else $error("completed flag ignored outside cyclic chained mode");

    chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        eng_stat.completion_event && eng_stat.complete_flag
        |=> (s.ctrl.completion_irq == $past(s.regs.completion_irq_enable)))
        else $error("completion interrupt not gated by enable");

    chk_stop_waits_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.state == smcc_pkg::ST_STOPPING) && eng_stat.busy |=> !s.ctrl.halted)
        else $error("halted with transfers in flight");

    chk_reset_flushes: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.state == smcc_pkg::ST_RESETTING)
        |-> s.ctrl.flush_pending && s.ctrl.terminate_streams && !s.ctrl.accept_work)
        else $error("soft reset without flush");

    chk_reset_bit_read: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s.bus.rvalid) && s.bus.rd_ctrl
        |-> (s.bus.rdata[smcc_pkg::SOFT_RESET_BIT]
             == ($past(s.state) == smcc_pkg::ST_RESETTING)))
        else $error("soft reset bit does not track the reset");

    chk_fixed_multichan: assert property (@(posedge aclk) disable iff (!aresetn)
        multichannel |-> (s.ctrl.aw_burst == smcc_pkg::BURST_INCR))
        else $error("fixed bursts in multichannel configuration");

endmodule

// file: rtl/smcc_pkg.sv
// Package for the stream-to-memory channel control block: map, fields, types
package smcc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] WRITE_CHANNEL_CONTROL_OFFSET = 8'h30;
    localparam logic [7:0] WRITE_CHANNEL_STATUS_OFFSET  = 8'h34;

    // ------------------------------------------------------------
    // Field positions of write_channel_control
    // ------------------------------------------------------------
    localparam int unsigned RUN_STOP_BIT     = 0;
    localparam int unsigned FIXED_ONE_BIT    = 1;
    localparam int unsigned SOFT_RESET_BIT   = 2;
    localparam int unsigned FIXED_ADDR_BIT   = 3;
    localparam int unsigned CYCLIC_BIT       = 4;
    localparam int unsigned RSVD_LO_BIT      = 5;
    localparam int unsigned RSVD_HI_BIT      = 11;
    localparam int unsigned COMPLETION_BIT   = 12;

    // Field positions of the status word
    localparam int unsigned STAT_HALTED_BIT  = 0;
    localparam int unsigned STAT_STOPPING_BIT = 1;
    localparam int unsigned STAT_RESETTING_BIT = 2;
    localparam int unsigned STAT_BUSY_BIT    = 3;

    // ------------------------------------------------------------
    // Bus and burst encodings
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    localparam logic [1:0] BURST_FIXED   = 2'h0;
    localparam logic [1:0] BURST_INCR    = 2'h1;
    localparam logic [7:0] LEN_MAX_FIXED = 8'h0f;
    localparam logic [7:0] LEN_MAX_INCR  = 8'hff;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_HALTED    = 4'h1,
        ST_RUNNING   = 4'h2,
        ST_STOPPING  = 4'h4,
        ST_RESETTING = 4'h8
    } smcc_state_t;

    typedef struct packed {
        logic run_stop;
        logic soft_reset;
        logic fixed_addr;
        logic cyclic;
        logic completion_irq_enable;
    } smcc_regs_t;

    localparam smcc_regs_t REGS_RESET = '{default: 1'b0};

    // Status from the datapath and descriptor engine
    typedef struct packed {
        logic busy;
        logic update_pending;
        logic error_event;
        logic completion_event;
        logic complete_flag;
        logic peer_reset_req;
    } smcc_eng_stat_t;

    // Controls to the datapath and descriptor engine
    typedef struct packed {
        logic       accept_work;
        logic       halted;
        logic       flush_pending;
        logic       terminate_streams;
        logic       engine_reset;
        logic [1:0] aw_burst;
        logic [7:0] aw_len_max;
        logic       ignore_complete;
        logic       completion_irq;
    } smcc_eng_ctrl_t;

    typedef struct packed {
        logic              awready;
        logic              aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic              wready;
        logic              w_full;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              rd_ctrl;
    } smcc_bus_t;

    typedef struct packed {
        smcc_state_t    state;
        smcc_regs_t     regs;
        smcc_eng_ctrl_t ctrl;
        smcc_bus_t      bus;
    } smcc_all_t;

endpackage

// file: testbench/smcc_engine_model.sv
// Behavioural model of the datapath and write-back queue behind the channel control
`timescale 1ns/1ps
module smcc_engine_model (
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // Bench commands: drain time, event pulses
    input  wire logic [7:0]               drain,
    input  wire logic [3:0]               pulse,
    // Control block side
    input  wire smcc_pkg::smcc_eng_ctrl_t eng_ctrl,
    output smcc_pkg::smcc_eng_stat_t      eng_stat
);
    logic [7:0] work;
    logic [7:0] queue;
    // Work drains only once new work stops; write-backs trail it by four cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            work  <= 8'h00;
            queue <= 8'h00;
        end else begin
            work  <= eng_ctrl.accept_work ? drain : work - {7'h00, work != 8'h00};
            queue <= eng_ctrl.accept_work ? drain + 8'h04 : queue - {7'h00, queue != 8'h00};
        end
    end
    assign eng_stat = {work != 8'h00, queue != 8'h00, pulse[0], pulse[1], pulse[3], pulse[2]};
endmodule

// file: testbench/stream_to_memory_channel_control_bench.sv
// Self-checking bench for the stream-to-memory channel control block
`timescale 1ns/1ps
module stream_to_memory_channel_control_bench;
    logic        aclk, aresetn, sg, mc;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr, drain;
    logic [31:0] wdata, rdata, rd_val;
    logic [1:0]  bresp, rresp, resp;
    logic [3:0]  pulse, wstrb, strb;
    int          n_fail, checked;
    smcc_pkg::smcc_eng_stat_t st;
    smcc_pkg::smcc_eng_ctrl_t ct;

    smcc_channel_control dut (.aclk, .aresetn, .sg_mode(sg), .multichannel(mc),
        .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .eng_stat(st), .eng_ctrl(ct));
    smcc_engine_model peer (.aclk, .aresetn, .drain, .pulse, .eng_ctrl(ct), .eng_stat(st));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= strb;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bready && bvalid));
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rready && rvalid));
        resp = rresp;
        rd_val = rdata;
        rready <= 1'b0;
    endtask
    task automatic ev(input logic [3:0] p);
        @(posedge aclk) pulse <= p;
        @(posedge aclk) pulse <= 4'h0;
        #1;
    endtask
    task automatic wait_halt;
        for (int i = 0; i < 100 && ct.halted !== 1'b1; i++) @(posedge aclk);
        chk(ct.halted, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_fields;
        rd(8'h30);
        chk(rd_val, 32'h2);
        wr(8'h30, 32'hffff_fffa); // Idle, no realignment engine
        rd(8'h30);
        chk(rd_val, 32'h101a);
        #1 chk(ct.aw_burst, mc ? smcc_pkg::BURST_INCR : smcc_pkg::BURST_FIXED);
        chk(ct.aw_len_max, mc ? smcc_pkg::LEN_MAX_INCR : smcc_pkg::LEN_MAX_FIXED);
        chk(ct.ignore_complete, sg & !mc);
        ev(4'ha);
        chk(ct.completion_irq, 1'b1);
        ev(4'h2);
        chk(ct.completion_irq, 1'b0);
        wr(8'h30, 32'h0);
        ev(4'ha);
        chk(ct.completion_irq, 1'b0);
        // Low byte masked: run and reset bits must not land
        strb = 4'h2;
        wr(8'h30, 32'h1005);
        rd(8'h30);
        chk(rd_val, 32'h1002);
        strb = 4'hf;
        wr(8'h30, 32'h0);
    endtask
    task automatic t_stop;
        wr(8'h30, 32'h1);
        #1 chk({ct.accept_work, ct.halted}, 2'b10);
        chk(resp, smcc_pkg::RESP_OKAY);
        wr(8'h30, 32'h0);
        #1 chk({ct.accept_work, ct.halted, ct.terminate_streams}, 3'b001);
        chk(ct.flush_pending, !sg);
        wait_halt();
        chk(st.update_pending, !sg);
        rd(8'h34);
        chk(rd_val[0], 1'b1);
    endtask
    task automatic t_error_reset;
        wr(8'h30, 32'h1);
        ev(4'h1);
        rd(8'h30);
        chk(rd_val[0], 1'b0);
        wr(8'h30, 32'h1);
        wr(8'h30, 32'h4);
        #1 chk(ct.engine_reset, 1'b1);
        rd(8'h30);
        chk(rd_val, 32'h6);
        wait_halt();
        rd(8'h30);
        chk(rd_val, 32'h2);
        wr(8'h30, 32'h1);
        ev(4'h4);
        chk(ct.engine_reset, 1'b1);
        wait_halt();
        rd(8'h3c);
        chk(resp, smcc_pkg::RESP_SLVERR);
        chk(rd_val, 32'h0);
    endtask

    task automatic summarize;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, pulse, wstrb} = 56'h0;
        strb = 4'hf;
        drain = 8'h0c;
        n_fail = 0;
        checked = 0;
        for (int c = 0; c < 4; c++) begin
            aresetn <= 1'b0;
            sg <= c[0];
            mc <= c[1];
            repeat (10) @(posedge aclk);
            aresetn <= 1'b1;
            t_fields();
            t_stop();
            t_error_reset();
        end
        summarize();
    end
    initial begin
        #40000;
        n_fail++;
        summarize();
    end
endmodule
